// ==== pkg/kmrs_pkg.sv ====
// Shared constants, code tables and carrier types of the keyboard sender.
// Assumes a single 20 MHz clock; teleprinter bit and burst times below are turned into cycles here, Morse times stay in quarter units.
package kmrs_pkg;

    // Clock rate and word sizes
    localparam int CLK_KHZ = 20000;
    localparam int ASCII_W = 7;
    localparam int PAT_W = 8;
    localparam int SHREG_W = 10;
    localparam int MATRIX_KEYS = 46;
    localparam int QUEUE_DEPTH = 3;
    localparam int LINE_LIMIT = 64;

    // Morse timing: a unit lasts UNIT_MS_WPM / wpm milliseconds
    localparam int WPM_MIN = 8;
    localparam int WPM_MAX = 60;
    localparam int UNIT_MS_WPM = 1200;
    localparam int SUBS_PER_UNIT = 4;
    localparam int SUB_NUM = UNIT_MS_WPM * CLK_KHZ / SUBS_PER_UNIT;
    localparam int ELEM_SUBS = 8;
    localparam int DASH_EXTRA_SUBS = 8;
    localparam int LETTER_GAP_SUBS = 8;
    localparam int WORD_GAP_SUBS = 16;
    localparam int ERROR_DOTS = 8;
    // Dot length in quarter units per weight setting, lightest first
    localparam logic [3:0][3:0] WEIGHT_DOT_SUBS = {4'h5, 4'h4, 4'h3, 4'h1};

    // Teleprinter timing
    localparam int RTTY_BIT_US = 22000;
    localparam int RTTY_BIT_CYCLES = RTTY_BIT_US * CLK_KHZ / 1000;
    localparam int RTTY_FRAME_BITS = 8;
    localparam int BURST_MS = 100;
    localparam int BURST_CYCLES = BURST_MS * CLK_KHZ;

    // Character codes the block itself looks at
    localparam logic [6:0] ASC_CR = 7'h0D;
    localparam logic [6:0] ASC_PRINT_LO = 7'h20;
    localparam logic [6:0] ASC_PRINT_HI = 7'h5F;
    localparam logic [7:0] PAT_ERROR = 8'h00;
    localparam logic [7:0] PAT_WORD = 8'h01;

    // Pattern tables for A..Z then 0..9; Morse uses a leading marker bit, dash = 1
    localparam logic [8*36-1:0] MORSE_ALNUM =
        288'h05181A0C02120E1004170D1407060F161D0A080309110B191B1C3F2F272321203038_3C3E;
    localparam logic [8*36-1:0] RTTY_ALNUM =
        288'h03190E09010D1A14060B0F121C0C1816170A0510071E131D1511161713010A101507_0618;

    // Fixed messages
    localparam int TEST_LEN = 61;
    localparam logic [8*TEST_LEN-1:0] TEST_MSG =
        "THE QUICK BROWN FOX JUMPS OVER THE LAZY DOG'S BACK 0123456789";
    localparam logic [23:0] GENERAL_MSG = "CQ ";

    // Individually wired keys
    typedef struct packed {
        logic shiftLeft;
        logic shiftRight;
        logic testMessageKey;
        logic stationIdentKey;
        logic generalCallKey;
        logic userSeqKey;
        logic breakKey;
    } kmrs_keys_t;

    // Indicator lamps
    typedef struct packed {
        logic bufferFull;
        logic lineLengthWarning;
    } kmrs_status_t;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b000,
        SEQ_TEST = 3'b001,
        SEQ_IDENT = 3'b010,
        SEQ_GENERAL = 3'b011,
        SEQ_USER = 3'b100
    } kmrs_seq_t;

    typedef enum logic [1:0] {
        SH_IDLE = 2'b00,
        SH_RBIT = 2'b01,
        SH_MARK = 2'b10,
        SH_SPACE = 2'b11
    } kmrs_shift_t;

    // Default conversion table; address bit 7 selects Morse
    function automatic logic [255:0][7:0] kmrs_rom_default();
        logic [255:0][7:0] rom;
        rom = '0;
        for (int i = 0; i < 26; i++)
        begin
            rom[8'h41 + i] = RTTY_ALNUM[8*(35-i) +: 8];
            rom[8'hC1 + i] = MORSE_ALNUM[8*(35-i) +: 8];
        end
        for (int i = 0; i < 10; i++)
        begin
            rom[8'h30 + i] = RTTY_ALNUM[8*(9-i) +: 8];
            rom[8'hB0 + i] = MORSE_ALNUM[8*(9-i) +: 8];
        end
        rom[8'h20] = 8'h04;
        rom[8'h0D] = 8'h08;
        rom[8'h0A] = 8'h02;
        rom[8'hA0] = PAT_WORD;
        rom[8'hAE] = 8'h55;
        rom[8'hAC] = 8'h73;
        rom[8'hAF] = 8'h32;
        rom[8'hBF] = 8'h4C;
        rom[8'hA7] = 8'h5E;
        rom[8'hA8] = 8'h36;
        rom[8'hA9] = 8'h6D;
        rom[8'hBA] = 8'h45;
        rom[8'h87] = 8'h78;
        rom[8'hAD] = 8'h28;
        rom[8'h9C] = 8'h61;
        rom[8'hBB] = 8'h31;
        rom[8'h9D] = 8'h6A;
        rom[8'h8A] = 8'h2A;
        rom[8'h8D] = 8'h36;
        return rom;
    endfunction

    localparam logic [255:0][7:0] CONV_ROM_DEFAULT = kmrs_rom_default();

endpackage

// ==== verilog/kmrs_sync.sv ====
// Two-stage synchroniser for a bundle of pin levels.
// Assumes each bit is an independent slow level; no bus coherence is given.
`timescale 1ns/1ps
module kmrs_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Levels
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage1;

    // First stage feeds only the second
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            stage1 <= '0;
            dout <= '0;
        end
        else
        begin
            stage1 <= din;
            dout <= stage1;
        end
    end

endmodule

// ==== verilog/kmrs_keyboard.sv ====
// Dual-mode keyboard sender: matrix encoder, message sequencers, queue,
// code conversion, one-pattern buffer, 10-bit shifter and Morse keyer.
// Assumes all key and switch inputs are raw pins, synchronised here.
// Notes on behaviour
// [RULE1] Morse speed set from 8 to 60 wpm
// [RULE2] Full lamp alike; Morse never drives warning
// [RULE3] Power-up warning clears only by teleprinter return
// [RULE4] Morse blocks test message, other sequencers run
// [RULE5] Blank key in Morse sends eight dots
// [RULE6] Bracket keys send prosigns or shifted punctuation
// [RULE7] Ten Morse punctuation marks, others send error
// [RULE8] Morse break key holds keying on
// [RULE9] Four dot-to-gap weight ratios, 1:7 to 5:3
// [RULE10] 46 matrix keys plus seven wired keys
// [RULE11] Key closure gives seven-bit code in parallel
// [RULE12] Shift selects shifted code on dual keys
// [RULE13] Teleprinter break key forces loop open
// [RULE14] Lookup addressed by code plus mode bit
// [RULE15] Direct to shifter when idle, else buffered
// [RULE16] Shifter loads parallel, shifts bit per tick
// [RULE17] Mode routes serial bits to loop or keyer
// [RULE18] Keyer makes dots and dashes, keys sidetone
// [RULE19] 64 printing characters light warning, tone burst
// [RULE20] Ident, general call, user three characters
// [RULE21] Sequencers repeat while trigger held
// [RULE22] Test key sends the pangram message
// [RULE23] Three pending characters; full overwrites last
// [RULE24] Non-printing characters do not count
// [RULE25] Tables and call sign are build parameters
`timescale 1ns/1ps
module kmrs_keyboard #(
    parameter int SUB_NUM = kmrs_pkg::SUB_NUM,
    parameter int RTTY_BIT_CYCLES = kmrs_pkg::RTTY_BIT_CYCLES,
    parameter int BURST_CYCLES = kmrs_pkg::BURST_CYCLES,
    parameter logic [255:0][7:0] CONV_ROM = kmrs_pkg::CONV_ROM_DEFAULT,
    parameter int CALL_LEN = 8,
    parameter logic [8*CALL_LEN-1:0] CALL_SIGN = "AB1CD   ",
    parameter logic [23:0] USER_CHARS = "DX ",
    parameter logic LINE_WARN_AT_RESET = 1'b1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Key pins
    input wire logic [kmrs_pkg::MATRIX_KEYS-1:0] matrixKeys,
    input wire kmrs_pkg::kmrs_keys_t keys,
    // Operator controls
    input wire logic morseMode,
    input wire logic [5:0] speedWpm,
    input wire logic [1:0] weightSel,
    // Encoder output
    output logic [6:0] encodedChar,
    output logic encodedStrobe,
    // Line and radio outputs
    output logic loopMark,
    output logic keyOut,
    output logic sidetoneOn,
    // Indicators
    output kmrs_pkg::kmrs_status_t status
);

    localparam int KW = $bits(kmrs_pkg::kmrs_keys_t);
    localparam int SYNC_W = kmrs_pkg::MATRIX_KEYS + KW + 9;
    localparam int IDENT_LEN = 3 + CALL_LEN;
    localparam logic [8*IDENT_LEN-1:0] IDENT_MSG = {"DE ", CALL_SIGN};
    localparam int ACC_W = $clog2(SUB_NUM + 64);
    localparam int BIT_W = $clog2(RTTY_BIT_CYCLES + 1);
    localparam int BURST_W = $clog2(BURST_CYCLES + 1);

    logic [SYNC_W-1:0] pinsSync;
    logic [kmrs_pkg::MATRIX_KEYS-1:0] mkey;
    kmrs_pkg::kmrs_keys_t key;
    logic morse;
    logic [5:0] wpmRaw;
    logic [1:0] weight;

    // Every pin passes two flops before use
    kmrs_sync #(.WIDTH(SYNC_W)) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .din({matrixKeys, keys, morseMode, speedWpm, weightSel}),
        .dout(pinsSync)
    );
    assign {mkey, key, morse, wpmRaw, weight} = pinsSync;

    // Matrix key code: letters, digits, space, punctuation, control keys
    function automatic logic [6:0] keyAscii(input logic [5:0] idx, input logic sh);
        logic [6:0] c;
        logic [6:0] d;
        d = 7'(7'h30 + 7'(idx - 6'd26));
        if (idx < 6'd26)
            c = 7'(7'h41 + 7'(idx));
        else if (idx < 6'd36)
            c = sh ? (d ^ 7'h10) : d;
        else
        begin
            unique case (idx)
                6'h24: c = 7'h20;
                6'h25: c = 7'h2E;
                6'h26: c = 7'h2C;
                6'h27: c = sh ? 7'h3F : 7'h2F;
                6'h28: c = sh ? 7'h07 : 7'h3A;
                6'h29: c = sh ? 7'h1C : 7'h2D;
                6'h2A: c = sh ? 7'h1D : 7'h3B;
                6'h2B: c = 7'h0A;
                6'h2C: c = 7'h0D;
                default: c = 7'h00;
            endcase
        end
        return c;
    endfunction

    // Position of the marker bit, which is also the element count
    function automatic logic [3:0] elemCount(input logic [7:0] p);
        logic [3:0] n;
        n = 4'h0;
        for (int b = 0; b < 8; b++)
            if (p[b])
                n = 4'(b);
        return n;
    endfunction

    // Scanning encoder with per-key history for n-key rollover
    logic [5:0] scanIdx;
    logic [kmrs_pkg::MATRIX_KEYS-1:0] keyPrev;
    logic newKey;
    assign newKey = mkey[scanIdx] & ~keyPrev[scanIdx];

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            scanIdx <= 6'h00;
        else if (scanIdx == 6'(kmrs_pkg::MATRIX_KEYS - 1))
            scanIdx <= 6'h00; // [RULE10]
        else
            scanIdx <= scanIdx + 6'h01;
    end

    // Only a change from open to closed yields a character
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            keyPrev <= '0;
            encodedChar <= 7'h00;
            encodedStrobe <= 1'b0;
        end
        else
        begin
            keyPrev[scanIdx] <= mkey[scanIdx];
            encodedChar <= keyAscii(scanIdx, key.shiftLeft | key.shiftRight); // [RULE11] [RULE12]
            encodedStrobe <= newKey;
        end
    end

    // Message sequencers share one engine; a held key restarts at idle
    kmrs_pkg::kmrs_seq_t seqSel;
    logic [5:0] seqIdx;
    logic [6:0] seqChar;
    logic seqLast;
    logic seqPush;
    logic [1:0] qCount;
    logic qFull;
    assign qFull = qCount == 2'(kmrs_pkg::QUEUE_DEPTH);
    // A sequencer waits for room rather than overwrite
    assign seqPush = (seqSel != kmrs_pkg::SEQ_IDLE) & ~qFull & ~encodedStrobe;

    always_comb
    begin
        seqChar = 7'h00;
        seqLast = 1'b1;
        unique case (seqSel)
            kmrs_pkg::SEQ_TEST:
            begin
                seqChar = kmrs_pkg::TEST_MSG[8*(kmrs_pkg::TEST_LEN-1-int'(seqIdx)) +: 7]; // [RULE22]
                seqLast = seqIdx == 6'(kmrs_pkg::TEST_LEN - 1);
            end
            kmrs_pkg::SEQ_IDENT:
            begin
                seqChar = IDENT_MSG[8*(IDENT_LEN-1-int'(seqIdx)) +: 7]; // [RULE20] [RULE25]
                seqLast = seqIdx == 6'(IDENT_LEN - 1);
            end
            kmrs_pkg::SEQ_GENERAL:
            begin
                seqChar = kmrs_pkg::GENERAL_MSG[8*(2-int'(seqIdx)) +: 7]; // [RULE20]
                seqLast = seqIdx == 6'h02;
            end
            kmrs_pkg::SEQ_USER:
            begin
                seqChar = USER_CHARS[8*(2-int'(seqIdx)) +: 7]; // [RULE20] [RULE25]
                seqLast = seqIdx == 6'h02;
            end
            default:
            begin
                seqChar = 7'h00;
                seqLast = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            seqSel <= kmrs_pkg::SEQ_IDLE;
            seqIdx <= 6'h00;
        end
        else if (seqSel == kmrs_pkg::SEQ_TEST && morse)
            seqSel <= kmrs_pkg::SEQ_IDLE; // [RULE4]
        else if (seqSel == kmrs_pkg::SEQ_IDLE)
        begin
            seqIdx <= 6'h00;
            // Level start, so a held key repeats the message
            if (key.testMessageKey && !morse)
                seqSel <= kmrs_pkg::SEQ_TEST; // [RULE4] [RULE21]
            else if (key.stationIdentKey)
                seqSel <= kmrs_pkg::SEQ_IDENT; // [RULE21]
            else if (key.generalCallKey)
                seqSel <= kmrs_pkg::SEQ_GENERAL; // [RULE21]
            else if (key.userSeqKey)
                seqSel <= kmrs_pkg::SEQ_USER; // [RULE21]
        end
        else if (seqPush)
        begin
            if (seqLast)
                seqSel <= kmrs_pkg::SEQ_IDLE;
            else
                seqIdx <= seqIdx + 6'h01;
        end
    end

    // Three-character queue; a keystroke while full replaces the tail
    logic [2:0][6:0] queue;
    logic [2:0][6:0] next_queue;
    logic [1:0] next_count;
    logic push;
    logic pop;
    logic [6:0] pushChar;
    logic fullLamp;
    assign push = encodedStrobe | seqPush;
    assign pushChar = encodedStrobe ? encodedChar : seqChar;

    always_comb
    begin
        next_queue = queue;
        next_count = qCount;
        if (pop)
        begin
            next_queue[0] = queue[1];
            next_queue[1] = queue[2];
            next_count = qCount - 2'h1;
        end
        if (push)
        begin
            if (next_count == 2'(kmrs_pkg::QUEUE_DEPTH))
                next_queue[2] = pushChar; // [RULE23]
            else
            begin
                next_queue[next_count] = pushChar;
                next_count = next_count + 2'h1;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            queue <= '0;
            qCount <= 2'h0;
            fullLamp <= 1'b0;
        end
        else
        begin
            queue <= next_queue;
            qCount <= next_count;
            fullLamp <= next_count == 2'(kmrs_pkg::QUEUE_DEPTH); // [RULE23] [RULE2]
        end
    end

    // Conversion lookup and the one-pattern buffer ahead of the shifter
    kmrs_pkg::kmrs_shift_t shState;
    logic [7:0] romPat;
    logic [7:0] bufPat;
    logic [6:0] bufChar;
    logic bufValid;
    logic shIdle;
    logic load;
    logic [7:0] loadPat;
    logic [6:0] loadChar;
    assign romPat = CONV_ROM[{morse, queue[0]}]; // [RULE14]
    assign shIdle = shState == kmrs_pkg::SH_IDLE;
    assign load = shIdle & (bufValid | (qCount != 2'h0));
    assign pop = (qCount != 2'h0) & (~bufValid | shIdle);
    assign loadPat = bufValid ? bufPat : romPat; // [RULE15]
    assign loadChar = bufValid ? bufChar : queue[0];

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            bufPat <= 8'h00;
            bufChar <= 7'h00;
            bufValid <= 1'b0;
        end
        else if (pop && !(shIdle && !bufValid))
        begin
            bufPat <= romPat; // [RULE15]
            bufChar <= queue[0];
            bufValid <= 1'b1;
        end
        else if (load)
            bufValid <= 1'b0;
    end

    // Quarter-unit tick scaled by speed; accumulating avoids a divider
    logic [5:0] wpm;
    logic [ACC_W-1:0] acc;
    logic [ACC_W-1:0] accSum;
    logic subTick;
    assign wpm = (wpmRaw < 6'(kmrs_pkg::WPM_MIN)) ? 6'(kmrs_pkg::WPM_MIN) :
                 (wpmRaw > 6'(kmrs_pkg::WPM_MAX)) ? 6'(kmrs_pkg::WPM_MAX) : wpmRaw; // [RULE1]
    assign accSum = acc + ACC_W'(wpm);
    assign subTick = accSum >= ACC_W'(SUB_NUM);

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            acc <= '0;
        else if (subTick)
            acc <= accSum - ACC_W'(SUB_NUM); // [RULE1]
        else
            acc <= accSum;
    end

    // Shifter and Morse element timing
    logic [9:0] shReg;
    logic [3:0] shCnt;
    logic [4:0] subTimer;
    logic [BIT_W-1:0] bitTimer;
    logic [4:0] dotOn;
    logic [4:0] gapSubs;
    assign dotOn = 5'(kmrs_pkg::WEIGHT_DOT_SUBS[weight]); // [RULE9]
    assign gapSubs = 5'(kmrs_pkg::ELEM_SUBS) - dotOn; // [RULE9]

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            shState <= kmrs_pkg::SH_IDLE;
            shReg <= 10'h000;
            shCnt <= 4'h0;
            subTimer <= 5'h00;
            bitTimer <= '0;
        end
        else if (load && !morse)
        begin
            // Start bit, five code bits, stop bits; shifted out low first
            shReg <= {4'hF, loadPat[4:0], 1'b0}; // [RULE16] [RULE17]
            shCnt <= 4'(kmrs_pkg::RTTY_FRAME_BITS);
            bitTimer <= BIT_W'(RTTY_BIT_CYCLES - 1);
            shState <= kmrs_pkg::SH_RBIT;
        end
        else if (load)
        begin
            shState <= kmrs_pkg::SH_SPACE;
            if (loadPat == kmrs_pkg::PAT_ERROR)
            begin
                shReg <= 10'h000; // [RULE5] [RULE7]
                shCnt <= 4'(kmrs_pkg::ERROR_DOTS);
                subTimer <= 5'h00;
            end
            else
            begin
                // Left-justify so the first element sits at the top bit
                shReg <= 10'({loadPat, 2'b00} << (4'h8 - elemCount(loadPat))); // [RULE16] [RULE6]
                shCnt <= elemCount(loadPat);
                subTimer <= (loadPat == kmrs_pkg::PAT_WORD) ?
                    5'(kmrs_pkg::WORD_GAP_SUBS - 1) : 5'h00;
            end
        end
        else if (shState == kmrs_pkg::SH_RBIT)
        begin
            if (bitTimer == '0)
            begin
                shReg <= {1'b1, shReg[9:1]}; // [RULE16]
                shCnt <= shCnt - 4'h1;
                bitTimer <= BIT_W'(RTTY_BIT_CYCLES - 1);
                if (shCnt == 4'h1)
                    shState <= kmrs_pkg::SH_IDLE;
            end
            else
                bitTimer <= bitTimer - BIT_W'(1);
        end
        else if (subTick && shState != kmrs_pkg::SH_IDLE)
        begin
            if (subTimer != 5'h00)
                subTimer <= subTimer - 5'h01;
            else if (shState == kmrs_pkg::SH_MARK)
            begin
                shState <= kmrs_pkg::SH_SPACE;
                subTimer <= (shCnt == 4'h0) ?
                    5'(gapSubs + 5'(kmrs_pkg::LETTER_GAP_SUBS) - 5'h01) : 5'(gapSubs - 5'h01);
            end
            else if (shCnt != 4'h0)
            begin
                // Unequal lengths: a dash adds to the weighted dot length
                shState <= kmrs_pkg::SH_MARK; // [RULE18]
                subTimer <= shReg[9] ?
                    5'(dotOn + 5'(kmrs_pkg::DASH_EXTRA_SUBS) - 5'h01) : 5'(dotOn - 5'h01);
                shReg <= {shReg[8:0], 1'b0}; // [RULE16]
                shCnt <= shCnt - 4'h1;
            end
            else
                shState <= kmrs_pkg::SH_IDLE;
        end
    end

    // Line length count, teleprinter only
    logic [6:0] lineCnt;
    logic lineHit;
    logic printing;
    logic [BURST_W-1:0] burstCnt;
    logic warnLamp;
    // Lamps come from separate flops, one process each
    assign status = '{bufferFull: fullLamp, lineLengthWarning: warnLamp};
    assign printing = loadChar >= kmrs_pkg::ASC_PRINT_LO && loadChar <= kmrs_pkg::ASC_PRINT_HI;
    assign lineHit = load & ~morse & printing & (lineCnt == 7'(kmrs_pkg::LINE_LIMIT - 1));

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            lineCnt <= 7'h00;
            warnLamp <= LINE_WARN_AT_RESET; // [RULE3]
        end
        else if (load && !morse)
        begin
            if (loadChar == kmrs_pkg::ASC_CR)
            begin
                lineCnt <= 7'h00; // [RULE3]
                warnLamp <= 1'b0;
            end
            else if (printing && lineCnt != 7'(kmrs_pkg::LINE_LIMIT))
            begin
                lineCnt <= lineCnt + 7'h01; // [RULE24] [RULE2]
                if (lineHit)
                    warnLamp <= 1'b1; // [RULE19]
            end
        end
    end

    // Warning tone burst
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            burstCnt <= '0;
        else if (lineHit)
            burstCnt <= BURST_W'(BURST_CYCLES); // [RULE19]
        else if (burstCnt != '0)
            burstCnt <= burstCnt - BURST_W'(1);
    end

    // Output stages; Morse mode bridges the loop so it idles closed
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            loopMark <= 1'b1;
            keyOut <= 1'b0;
            sidetoneOn <= 1'b0;
        end
        else
        begin
            if (morse)
                loopMark <= 1'b1; // [RULE17]
            else if (key.breakKey)
                loopMark <= 1'b0; // [RULE13]
            else
                loopMark <= (shState == kmrs_pkg::SH_RBIT) ? shReg[0] : 1'b1; // [RULE17]
            keyOut <= morse & (key.breakKey | (shState == kmrs_pkg::SH_MARK)); // [RULE8] [RULE18]
            sidetoneOn <= (morse & (key.breakKey | (shState == kmrs_pkg::SH_MARK))) |
                          (burstCnt != '0); // [RULE18] [RULE19]
        end
    end

endmodule

// ==== tb/kmrs_sva.sv ====
// Output checks of the keyboard sender.
// Assumes 2 sync flops and 1 output flop: 4 cycles settle.
`timescale 1ns/1ps
module kmrs_sva (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Inputs
    input wire logic [45:0] matrixKeys,
    input wire kmrs_pkg::kmrs_keys_t keys,
    input wire logic morseMode,
    // Outputs
    input wire logic encodedStrobe,
    input wire logic loopMark,
    input wire logic keyOut,
    input wire logic sidetoneOn,
    input wire kmrs_pkg::kmrs_status_t status
);
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    // Mode held long enough to pass the synchroniser
    sequence morse_s;
        morseMode[*4];
    endsequence
    sequence rtty_s;
        !morseMode[*4];
    endsequence
    morse_loop_a: assert property (morse_s |-> loopMark)
        else $error("loop open in Morse");
    rtty_key_a: assert property (rtty_s |-> !keyOut)
        else $error("keyed in teleprinter");
    morse_brk_a: assert property ((morseMode && keys.breakKey)[*4] |-> keyOut)
        else $error("break not keying");
    rtty_brk_a: assert property ((!morseMode && keys.breakKey)[*4] |-> !loopMark)
        else $error("break not opening");
    tone_key_a: assert property (keyOut |-> sidetoneOn)
        else $error("key without tone");
    morse_warn_a: assert property (morse_s |-> $stable(status.lineLengthWarning))
        else $error("warning moved in Morse");
    warn_clear_a: assert property ($fell(status.lineLengthWarning) |-> !$past(morseMode, 3))
        else $error("warning cleared in Morse");
    strobe_cause_a: assert property (encodedStrobe |-> $past(|matrixKeys, 3))
        else $error("strobe without key");
endmodule
bind kmrs_keyboard kmrs_sva i_sva (.*);

// ==== tb/kmrs_loop_rx.sv ====
// Teleprinter loop receiver: start, five data bits, two stops.
// Assumes loopMark 1 = mark and BIT cycles per bit.
`timescale 1ns/1ps
module kmrs_loop_rx #(
    parameter int BIT = 20
) (
    // Clock and line
    input wire logic ref_clk,
    input wire logic loopMark
);
    logic [7:0] frame;
    logic [4:0] got[$];
    // Mid-bit sampling; a bad stop stores 1F
    initial
    begin
        forever
        begin
            @(negedge loopMark);
            repeat (BIT / 2) @(posedge ref_clk);
            for (int i = 0; i < 8; i++)
            begin
                frame[i] = loopMark;
                if (i < 7) repeat (BIT) @(posedge ref_clk);
            end
            got.push_back(frame[7:6] == 2'b11 ? frame[5:1] : 5'h1F);
        end
    end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench of the keyboard sender.
// Assumes shortened timing; expectations come from the package.
`timescale 1ns/1ps
module testbench;
    localparam int BITC = 100;
    logic ref_clk, rst_n, morseMode, encodedStrobe, loopMark, keyOut, sidetoneOn;
    logic [45:0] matrixKeys;
    kmrs_pkg::kmrs_keys_t keys;
    logic [5:0] speedWpm;
    logic [1:0] weightSel;
    logic [6:0] encodedChar;
    kmrs_pkg::kmrs_status_t status;
    int err_total, samples_checked, n, len, dots;
    kmrs_keyboard #(.SUB_NUM(480), .RTTY_BIT_CYCLES(BITC), .BURST_CYCLES(50)) i_dut (.*);
    kmrs_loop_rx #(.BIT(BITC)) i_rx (.ref_clk(ref_clk), .loopMark(loopMark));
    // Drives land 1 ns after the edge
    task automatic tick(int c);
        repeat (c) @(posedge ref_clk);
        #1;
    endtask
    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    // Hold a key until its strobe
    task automatic press(int idx, int code);
        matrixKeys[idx] = 1'b1;
        n = 0;
        while (encodedStrobe !== 1'b1 && n < 80)
        begin
            tick(1);
            n++;
        end
        check("encodedChar", {1'b1, code[6:0]}, {encodedStrobe, encodedChar});
        matrixKeys[idx] = 1'b0;
    endtask
    // Next key-down span, zero if none
    task automatic span();
        n = 0;
        while (keyOut !== 1'b1 && n < 2000)
        begin
            tick(1);
            n++;
        end
        len = 0;
        while (keyOut === 1'b1 && len < 2000)
        begin
            tick(1);
            len++;
        end
    endtask
    task automatic t_morse();
        for (int w = 0; w < 4; w++)
        begin
            weightSel = w[1:0];
            speedWpm = w[0] ? 6'h1E : 6'h3C;
            tick(60);
            press(4, 'h45);
            span();
            check("dot length", kmrs_pkg::WEIGHT_DOT_SUBS[w] * 480 / speedWpm, len[7:0]);
        end
        tick(60);
        press(45, 'h00);
        dots = 0;
        for (int k = 0; k < 9; k++)
        begin
            span();
            if (len > 0) dots++;
        end
        check("error dots", 8'h08, dots[7:0]);
        keys.breakKey = 1'b1;
        tick(5);
        check("break keying", 8'h03, {6'h00, keyOut, sidetoneOn});
        keys.breakKey = 1'b0;
        press(44, 'h0D);
        tick(1500);
        check("warning", 8'h01, {7'h00, status.lineLengthWarning});
        keys.testMessageKey = 1'b1;
        tick(10);
        keys.testMessageKey = 1'b0;
        span();
        check("test key in Morse", 8'h00, len[7:0]);
    endtask
    task automatic t_rtty();
        morseMode = 1'b0;
        tick(60);
        press(44, 'h0D);
        tick(BITC * 9);
        check("warning", 8'h00, {7'h00, status.lineLengthWarning});
        i_rx.got.delete();
        for (int i = 0; i < 6; i++)
        begin
            press(i, 'h41 + i);
            tick(60);
        end
        check("bufferFull", 8'h01, {7'h00, status.bufferFull});
        tick(BITC * 45);
        check("frames", 8'h05, 8'(i_rx.got.size()));
        for (int k = 0; k < 5; k++)
            check("loop code", kmrs_pkg::CONV_ROM_DEFAULT[65 + (k < 4 ? k : 5)][4:0], i_rx.got[k]);
        keys.shiftLeft = 1'b1;
        tick(4);
        press(41, 'h1C);
        keys.shiftLeft = 1'b0;
        keys.breakKey = 1'b1;
        tick(5);
        check("loopMark", 8'h00, {7'h00, loopMark});
        keys.breakKey = 1'b0;
        tick(BITC * 18);
        morseMode = 1'b1;
        keys.stationIdentKey = 1'b1;
        tick(10);
        keys.stationIdentKey = 1'b0;
        span();
        check("ident dash", (kmrs_pkg::WEIGHT_DOT_SUBS[3] + 8) * 16, len[7:0]);
    endtask
    task automatic wrap_up();
        if (err_total == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Clock, 50 ns period
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // Main sequence
    initial
    begin
        err_total = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        matrixKeys = '0;
        keys = '0;
        morseMode = 1'b1;
        speedWpm = 6'h3C;
        weightSel = 2'h0;
        tick(20);
        rst_n = 1'b1;
        tick(1);
        check("reset levels", 8'h11, {3'h0, loopMark, keyOut, sidetoneOn, status});
        t_morse();
        t_rtty();
        wrap_up();
    end
    // Watchdog well past the expected run
    initial
    begin
        #3000000;
        err_total++;
        wrap_up();
    end
endmodule
